// ==== fgc_top.sv ====
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fgc_top
	import fgc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic [31:0] cpu_addr_out_in,
	input wire logic periph_ready_in,
	input wire logic nmi_n,
	input wire logic [3:0] int_or_io_flag_pins,
	input wire logic [3:0] flag_is_int,
	input wire logic [4:0] int_enabled,
	output logic [FGC_NPORTS-1:0] fifo_flush,
	output logic periph_ready,
	output logic phase_clock_one,
	output logic phase_clock_three,
	output logic exec_en,
	output logic [31:0] ext_addr,
	output logic ext_data_oe,
	output logic ext_strobe_n,
	output logic [4:0] wake_service,
	output logic irq
);
	// ==========================================================
	// pin synchronisers: three flops, change counts when 2 and 3 agree
	logic [4:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
	assign pin_raw = {nmi_n, int_or_io_flag_pins};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 5'h1F;
			s2_q <= 5'h1F;
			s3_q <= 5'h1F;
			pin_q <= 5'h1F;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 5; i++) begin
				if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
			end
		end
	end
	// ==========================================================
	// ahb-lite slave, zero wait states
	logic [31:0] ctrl_q, stword_q;
	logic [FGC_IRQ_W-1:0] ist_q, imask_q;
	logic aw_q;
	logic [7:0] aa_q;
	logic ph_valid;
	fgc_state_t st_q;
	assign ph_valid = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw_q <= 1'b0;
			aa_q <= 8'h00;
		end else begin
			aw_q <= ph_valid && hwrite;
			aa_q <= ph_valid ? haddr[7:0] : 8'h00;
		end
	end
	logic reti;
	assign reti = aw_q && aa_q == FGC_ADDR_CTRL && hwdata[FGC_CTRL_RETI];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= 32'h0000_0000;
			stword_q <= 32'h0000_0000;
			imask_q <= '0;
		end else if (aw_q) begin
			case (aa_q)
				FGC_ADDR_CTRL: ctrl_q <= {30'h0, hwdata[1:0]};
				FGC_ADDR_STWORD: stword_q <= hwdata;
				FGC_ADDR_IRQ_MASK: imask_q <= hwdata[FGC_IRQ_W-1:0];
				default: ;
			endcase
		end else if (st_q != FGC_RUN) begin
			ctrl_q[FGC_CTRL_STOP] <= 1'b0;
		end
	end
	// ready and okay come from flops that never leave their reset level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	// read data taken at the address phase so it stands through the data phase;
	// limitation: a read right behind a write to the same word sees the old value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ph_valid && !hwrite) begin
			case (haddr[7:0])
				FGC_ADDR_CTRL: hrdata <= ctrl_q;
				FGC_ADDR_STATUS: hrdata <= {27'h0, st_q == FGC_RUN, st_q, exec_en, periph_ready};
				FGC_ADDR_IRQ_STAT: hrdata <= {29'h0, ist_q};
				FGC_ADDR_IRQ_MASK: hrdata <= {29'h0, imask_q};
				FGC_ADDR_STWORD: hrdata <= stword_q;
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
	// ==========================================================
	// flush: two consecutive cpu writes to the same port address
	logic [FGC_NPORTS-1:0] hit, prev_q;
	always_comb begin
		for (int p = 0; p < FGC_NPORTS; p++) begin
			hit[p] = cpu_wr && cpu_addr == FGC_FLUSH_BASE + FGC_FLUSH_STEP * 32'(p);
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= '0;
			fifo_flush <= '0;
		end else begin
			prev_q <= hit;
			fifo_flush <= hit & prev_q;
		end
	end
	// ==========================================================
	// nmi bus-grant
	logic nmi_prev_q, nmi_fall, grant_en, grant_q;
	assign grant_en = stword_q[FGC_ST_GRANT_LO+1:FGC_ST_GRANT_LO] == FGC_ST_GRANT_ON;
	assign nmi_fall = nmi_prev_q && !pin_q[4];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_prev_q <= 1'b1;
			grant_q <= 1'b0;
			periph_ready <= 1'b0;
		end else begin
			nmi_prev_q <= pin_q[4];
			// grant holds until nmi released; stalls otherwise persist
			if (nmi_fall && grant_en) grant_q <= 1'b1;
			else if (pin_q[4]) grant_q <= 1'b0;
			periph_ready <= periph_ready_in || (nmi_fall && grant_en) || grant_q;
		end
	end
	// ==========================================================
	// clock-stop state machine
	logic [4:0] wake_pin;
	logic [2:0] low_cnt_q;
	logic [1:0] rs_cnt_q;
	logic div_q;
	assign wake_pin = ~pin_q & {1'b1, flag_is_int};
	logic wake_any;
	assign wake_any = |wake_pin;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= FGC_RUN;
			low_cnt_q <= 3'h0;
			rs_cnt_q <= 2'h0;
		end else begin
			case (st_q)
				FGC_RUN: begin
					// emulation keeps clocks running
					if (ctrl_q[FGC_CTRL_STOP] && !ctrl_q[FGC_CTRL_EMU]) st_q <= FGC_STOPPED;
					low_cnt_q <= 3'h0;
				end
				FGC_STOPPED: begin
					if (|wake_pin) begin
						if (low_cnt_q == 3'(FGC_WAKE_HOLD_CLKS - 1)) begin
							st_q <= FGC_RESTART;
							rs_cnt_q <= 2'h0;
						end else begin
							low_cnt_q <= low_cnt_q + 3'h1;
						end
					end else begin
						low_cnt_q <= 3'h0;
					end
				end
				FGC_RESTART: begin
					if (rs_cnt_q == 2'(FGC_RESTART_CLKS - 1)) st_q <= FGC_RUN;
					else rs_cnt_q <= rs_cnt_q + 2'h1;
				end
				default: st_q <= FGC_RUN;
			endcase
		end
	end
	// phase clocks from one divider flop: always complementary
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 1'b0;
			phase_clock_one <= 1'b0;
			phase_clock_three <= 1'b1;
		end else if (st_q == FGC_RUN) begin
			div_q <= ~div_q;
			phase_clock_one <= ~div_q;
			phase_clock_three <= div_q;
		end else begin
			phase_clock_one <= 1'b1;
			phase_clock_three <= 1'b0;
		end
	end
	// ==========================================================
	// execution gating and external bus idle
	logic hold_q;
	logic [2:0] svc_cnt_q [5];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			exec_en <= 1'b1;
			ext_addr <= 32'h0000_0000;
			ext_data_oe <= 1'b0;
			ext_strobe_n <= 1'b1;
			hold_q <= 1'b0;
			wake_service <= 5'h00;
		end else begin
			exec_en <= st_q == FGC_RUN && !hold_q && !ctrl_q[FGC_CTRL_STOP];
			if (st_q == FGC_RUN) begin
				ext_addr <= cpu_addr_out_in;
				ext_data_oe <= cpu_wr;
				ext_strobe_n <= !cpu_wr;
			end else begin
				ext_data_oe <= 1'b0;
				ext_strobe_n <= 1'b1;
			end
			wake_service <= 5'h00;
			for (int i = 0; i < 5; i++) begin
				if (st_q != FGC_RUN && svc_cnt_q[i] == 3'(FGC_SERVICE_CLKS - 1)
					&& int_enabled[i] && wake_pin[i]) begin
					wake_service[i] <= 1'b1;
				end
			end
			if (|wake_service) hold_q <= 1'b1;
			else if (reti) hold_q <= 1'b0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 5; i++) svc_cnt_q[i] <= 3'h0;
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (st_q == FGC_RUN || !wake_pin[i]) svc_cnt_q[i] <= 3'h0;
				else if (svc_cnt_q[i] != 3'h7) svc_cnt_q[i] <= svc_cnt_q[i] + 3'h1;
			end
		end
	end
	// ==========================================================
	// interrupts: set wins over write-one-to-clear
	logic [FGC_IRQ_W-1:0] ev, clr;
	assign ev = {st_q == FGC_RESTART && rs_cnt_q == 2'h0, nmi_fall && grant_en, |fifo_flush};
	assign clr = (aw_q && aa_q == FGC_ADDR_IRQ_STAT) ? hwdata[FGC_IRQ_W-1:0] : '0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_q <= '0;
			irq <= 1'b0;
		end else begin
			ist_q <= (ist_q & ~clr) | ev;
			irq <= |(((ist_q & ~clr) | ev) & imask_q);
		end
	end
	// ==========================================================
	// checks
	sequence s_two_writes(int p);
		hit[p] ##1 hit[p];
	endsequence
	property p_flush0;
		@(posedge hclk) disable iff (!hresetn) s_two_writes(0) |=> fifo_flush[0];
	endproperty
	a_flush0: assert property (p_flush0) else $error("flush missed");
	property p_flush_addr;
		@(posedge hclk) disable iff (!hresetn)
			(cpu_wr && cpu_addr == 32'h0010_0093) ##1 (cpu_wr && cpu_addr == 32'h0010_0093)
			|=> fifo_flush[5];
	endproperty
	a_flush_addr: assert property (p_flush_addr) else $error("port5 addr");
	property p_flush_single;
		@(posedge hclk) disable iff (!hresetn) fifo_flush[1] |-> $past(hit[1]) && $past(hit[1], 2);
	endproperty
	a_flush_single: assert property (p_flush_single) else $error("single flush");
	property p_grant_off;
		@(posedge hclk) disable iff (!hresetn)
			nmi_fall && !grant_q && stword_q[FGC_ST_GRANT_LO+1:FGC_ST_GRANT_LO] != FGC_ST_GRANT_ON
			|=> !grant_q;
	endproperty
	a_grant_off: assert property (p_grant_off) else $error("grant off");
	property p_grant;
		@(posedge hclk) disable iff (!hresetn) (nmi_fall && grant_en) |=> periph_ready;
	endproperty
	a_grant: assert property (p_grant) else $error("no grant");
	property p_h1_high;
		@(posedge hclk) disable iff (!hresetn) st_q == FGC_STOPPED ##1 st_q == FGC_STOPPED |-> phase_clock_one;
	endproperty
	a_h1_high: assert property (p_h1_high) else $error("h1 not high");
	property p_opp;
		@(posedge hclk) disable iff (!hresetn) phase_clock_one != phase_clock_three;
	endproperty
	a_opp: assert property (p_opp) else $error("phase clash");
	property p_restart;
		@(posedge hclk) disable iff (!hresetn) $rose(st_q == FGC_RESTART) |-> ##2 st_q == FGC_RUN;
	endproperty
	a_restart: assert property (p_restart) else $error("restart delay");
	property p_idle_bus;
		@(posedge hclk) disable iff (!hresetn) $past(st_q) != FGC_RUN |-> !ext_data_oe && ext_strobe_n;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("bus active");
	property p_stall;
		@(posedge hclk) disable iff (!hresetn)
			!grant_en && !grant_q && !periph_ready_in |=> !periph_ready;
	endproperty
	a_stall: assert property (p_stall) else $error("stall released");
	property p_no_exec;
		@(posedge hclk) disable iff (!hresetn) st_q != FGC_RUN |=> !exec_en;
	endproperty
	a_no_exec: assert property (p_no_exec) else $error("exec while stopped");
	property p_hold;
		@(posedge hclk) disable iff (!hresetn) hold_q |=> !exec_en;
	endproperty
	a_hold: assert property (p_hold) else $error("exec before return");
	property p_io_no_wake;
		@(posedge hclk) disable iff (!hresetn)
			st_q == FGC_STOPPED && (~pin_q & {1'b1, flag_is_int}) == 5'h00 |=> st_q == FGC_STOPPED;
	endproperty
	a_io_no_wake: assert property (p_io_no_wake) else $error("io pin woke");
	sequence s_calm_stop;
		st_q == FGC_STOPPED && !wake_any;
	endsequence
	sequence s_held_low;
		wake_any [*4];
	endsequence
	property p_wake_hold;
		@(posedge hclk) disable iff (!hresetn) s_calm_stop ##1 s_held_low |=> st_q == FGC_RESTART;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake missed");
	property p_svc_enabled;
		@(posedge hclk) disable iff (!hresetn) (wake_service & ~$past(int_enabled)) == 5'h00;
	endproperty
	a_svc_enabled: assert property (p_svc_enabled) else $error("disabled service");
	property p_emu;
		@(posedge hclk) disable iff (!hresetn)
			st_q == FGC_RUN && ctrl_q[FGC_CTRL_EMU] |=> st_q == FGC_RUN;
	endproperty
	a_emu: assert property (p_emu) else $error("stopped in emulation");
	property p_stop_entry;
		@(posedge hclk) disable iff (!hresetn)
			st_q == FGC_RUN && ctrl_q[FGC_CTRL_STOP] && !ctrl_q[FGC_CTRL_EMU] |=> st_q == FGC_STOPPED;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
	property p_irq_level;
		@(posedge hclk) disable iff (!hresetn) irq == |(ist_q & $past(imask_q));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level");
	property p_bus_okay;
		@(posedge hclk) disable iff (!hresetn) hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus not okay");
endmodule
`default_nettype wire

// ==== fgc_pkg.sv ====
package fgc_pkg;
	// ==========================================================
	// register map (byte addresses, AHB-Lite word registers)
	localparam logic [7:0] FGC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] FGC_ADDR_STATUS = 8'h04;
	localparam logic [7:0] FGC_ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] FGC_ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] FGC_ADDR_STWORD = 8'h10;
	// ==========================================================
	// ctrl fields
	localparam int FGC_CTRL_STOP = 0;
	localparam int FGC_CTRL_EMU = 1;
	localparam int FGC_CTRL_RETI = 2;
	// ==========================================================
	// status word field for grant enable
	localparam int FGC_ST_GRANT_LO = 18;
	localparam logic [1:0] FGC_ST_GRANT_ON = 2'b10;
	// ==========================================================
	// flush decode
	localparam logic [31:0] FGC_FLUSH_BASE = 32'h0010_0043;
	localparam logic [31:0] FGC_FLUSH_STEP = 32'h0000_0010;
	localparam int FGC_NPORTS = 6;
	// ==========================================================
	// irq status bits
	localparam int FGC_IRQ_FLUSH = 0;
	localparam int FGC_IRQ_GRANT = 1;
	localparam int FGC_IRQ_WAKE = 2;
	localparam int FGC_IRQ_W = 3;
	// ==========================================================
	// timing: input clocks, phase clock is input clock / 2
	localparam int FGC_WAKE_HOLD_CLKS = 4;
	localparam int FGC_RESTART_CLKS = 2;
	localparam int FGC_SERVICE_CLKS = 4;
	typedef enum logic [1:0] {FGC_RUN, FGC_STOPPED, FGC_RESTART} fgc_state_t;
endpackage

// ==== fgc_irq_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// interrupt sources, pins pulled up when idle
module fgc_irq_src (
	input wire logic hclk,
	output logic nmi_n,
	output logic [3:0] int_or_io_flag_pins
);
	initial begin
		nmi_n = 1'b1;
		int_or_io_flag_pins = 4'hF;
	end
	// pin 4 is nmi; low for n input clocks
	task automatic assert_pin(input int pin, input int n);
		@(posedge hclk);
		if (pin == 4) nmi_n <= 1'b0;
		else int_or_io_flag_pins[pin] <= 1'b0;
		repeat (n) @(posedge hclk);
		nmi_n <= 1'b1;
		int_or_io_flag_pins <= 4'hF;
	endtask
endmodule
`default_nettype wire

// ==== test_flush_grant_clockstop_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_flush_grant_clockstop_control
	import fgc_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, cpu_wr = 1'b0, periph_ready_in = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, cpu_addr = '0, cpu_addr_out_in = '0, hrdata, ext_addr;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [3:0] flag_is_int = 4'hF, flags;
	logic [4:0] int_enabled = 5'h00, wake_service;
	logic [FGC_NPORTS-1:0] fifo_flush;
	logic hreadyout, hresp, nmi_n, periph_ready, phase_clock_one, phase_clock_three;
	logic exec_en, ext_data_oe, ext_strobe_n, irq;
	logic [31:0] exp_q[$], got_q[$];
	int n_checks = 0, n_mismatch = 0;
	always #25 hclk = ~hclk;
	fgc_irq_src i_src (.hclk(hclk), .nmi_n(nmi_n), .int_or_io_flag_pins(flags));
	fgc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_addr_out_in(cpu_addr_out_in), .periph_ready_in(periph_ready_in), .nmi_n(nmi_n),
		.int_or_io_flag_pins(flags), .flag_is_int(flag_is_int), .int_enabled(int_enabled),
		.fifo_flush(fifo_flush), .periph_ready(periph_ready), .phase_clock_one(phase_clock_one),
		.phase_clock_three(phase_clock_three), .exec_en(exec_en), .ext_addr(ext_addr),
		.ext_data_oe(ext_data_oe), .ext_strobe_n(ext_strobe_n), .wake_service(wake_service),
		.irq(irq));
	// ==========================================================
	// checking
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// oldest note against each result as it shows
	always @(posedge hclk) begin
		if (fifo_flush !== '0) got_q.push_back({26'h0, fifo_flush});
		if (wake_service !== '0) got_q.push_back({27'h0, wake_service});
		if (got_q.size() > 0) begin
			if (exp_q.size() == 0) check(got_q.pop_front(), 64'hFFFF_FFFF_FFFF_FFFF, "unexpected result");
			else check(got_q.pop_front(), exp_q.pop_front(), "result");
		end
		if (hresetn) check(phase_clock_one ^ phase_clock_three, 64'h1, "phase");
	end
	// ==========================================================
	// bus and wait helpers
	task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= {24'h0, ad};
		hwrite <= wr;
		for (int ph = 0; ph < 2; ph++) begin
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (hreadyout !== 1'b1 && n < 50);
			if (n >= 50) begin
				n_mismatch++;
				summarize();
			end
			check(hresp, 1'b0, "response");
			htrans <= 2'b00;
			hwdata <= d;
		end
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] v;
		ahb(1'b1, ad, d, v);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] v;
		exp_q.push_back(e);
		ahb(1'b0, ad, 32'h0, v);
		got_q.push_back(v);
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return exec_en;
			1: return periph_ready;
			default: return phase_clock_one;
		endcase
	endfunction
	// must=0: the level may not be reached within lim
	task automatic await(input int w, input logic v, input int lim, input logic must);
		int n;
		n = 0;
		while (sig(w) !== v && n < lim) begin
			@(posedge hclk);
			n++;
		end
		check(sig(w) === v, must, "wait");
	endtask
	task automatic flush(input int p, input int nwr);
		@(posedge hclk);
		cpu_addr <= 32'h0010_0043 + 32'h10 * 32'(p);
		cpu_wr <= 1'b1;
		repeat (nwr) @(posedge hclk);
		cpu_wr <= 1'b0;
		if (nwr >= 2) exp_q.push_back(32'h1 << p);
		repeat (3) @(posedge hclk);
	endtask
	task automatic stop_chk();
		logic [31:0] ea;
		wr(FGC_ADDR_CTRL, 32'h1);
		await(0, 1'b0, 8, 1'b1);
		@(posedge hclk);
		ea = ext_addr;
		repeat (6) begin
			cpu_addr_out_in <= $urandom();
			@(posedge hclk);
			check(phase_clock_one, 1'b1, "clock held");
			check({ext_addr, ext_data_oe, ext_strobe_n}, {ea, 2'b01}, "bus idle");
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(37711));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(FGC_ADDR_STATUS, 32'h12);
		rd(FGC_ADDR_IRQ_STAT, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0);
		$display("test reset done");
		flush(0, 1);
		for (int p = 0; p < FGC_NPORTS; p++) flush(p, 2);
		rd(FGC_ADDR_IRQ_STAT, 32'h1);
		wr(FGC_ADDR_IRQ_MASK, 32'h7);
		repeat (2) @(posedge hclk);
		check(irq, 1'b1, "irq on");
		wr(FGC_ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge hclk);
		check(irq, 1'b0, "mask");
		wr(FGC_ADDR_IRQ_STAT, 32'h7);
		rd(FGC_ADDR_IRQ_STAT, 32'h0);
		$display("test flush done");
		// grant only for field value 10b
		for (int v = 0; v < 4; v++) begin
			wr(FGC_ADDR_STWORD, {12'h0, v[1:0], 18'h0} | ($urandom() & 32'h3_FFFF));
			fork
				i_src.assert_pin(4, 20);
				await(1, 1'b1, 12, v == 2);
			join
			repeat (8) @(posedge hclk);
		end
		$display("test grant done");
		wr(FGC_ADDR_CTRL, 32'h3);
		await(2, 1'b0, 4, 1'b1);
		await(2, 1'b1, 4, 1'b1);
		wr(FGC_ADDR_CTRL, 32'h0);
		$display("test emulation done");
		flag_is_int <= 4'hD;
		stop_chk();
		i_src.assert_pin(1, 10);
		await(2, 1'b0, 16, 1'b0);
		i_src.assert_pin(0, 2);
		await(2, 1'b0, 16, 1'b0);
		i_src.assert_pin(4, 5);
		await(2, 1'b0, 16, 1'b1);
		await(0, 1'b1, 10, 1'b1);
		int_enabled <= 5'h01;
		stop_chk();
		exp_q.push_back(32'h1);
		i_src.assert_pin(0, 5);
		await(2, 1'b0, 16, 1'b1);
		check(exec_en, 1'b0, "held");
		wr(FGC_ADDR_CTRL, 32'h4);
		await(0, 1'b1, 10, 1'b1);
		repeat (4) @(posedge hclk);
		check(exp_q.size(), 64'h0, "pending");
		$display("test clock stop done");
		summarize();
	end
endmodule
`default_nettype wire
